// File: tlic_pkg.sv
// constants, field layouts and carrier types of the two-level interrupt controller
package tlic_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// sizes
	localparam int NUM_SRC = 12;
	localparam int IDX_W = 4;
	localparam int DW = 8;
	localparam int AW = 8;
	localparam int VW = 16;

	////////////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [AW-1:0] ADDR_IE = 8'hA8;
	localparam logic [AW-1:0] ADDR_IP = 8'hB8;
	localparam logic [AW-1:0] ADDR_EIE = 8'hE6;
	localparam logic [AW-1:0] ADDR_EIP = 8'hF6;
	localparam logic [AW-1:0] ADDR_PEND_LO = 8'h01;
	localparam logic [AW-1:0] ADDR_PEND_HI = 8'h02;
	localparam logic [AW-1:0] ADDR_EVT_STAT = 8'h03;
	localparam logic [AW-1:0] ADDR_EVT_CLR = 8'h04;
	localparam logic [AW-1:0] ADDR_EVT_EN = 8'h05;
	localparam logic [AW-1:0] ADDR_ACTIVE = 8'h06;

	////////////////////////////////////////////////////////////////////////////////
	// field positions and reset values
	localparam int EA_BIT = 7;
	localparam int IE_SRC_W = 7;
	localparam int EIE_SRC_W = 5;
	localparam int PEND_HI_W = 4;
	localparam int EVT_TAKE_LO = 0;
	localparam int EVT_TAKE_HI = 1;
	localparam int EVT_RETI = 2;
	localparam int EVT_W = 3;
	localparam int ACT_LO_BIT = 0;
	localparam int ACT_HI_BIT = 1;
	localparam logic [DW-1:0] REG_RST = 8'h00;
	localparam logic [VW-1:0] VEC_BASE = 16'h0003;
	localparam logic [VW-1:0] VEC_STEP = 16'h0008;

	////////////////////////////////////////////////////////////////////////////////
	// timing in system clocks
	localparam int DETECT_CYCLES = 1;
	localparam int LCALL_CYCLES = 4;
	localparam int RESP_CYCLES = DETECT_CYCLES + LCALL_CYCLES;

	////////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic valid;
		logic level;
		logic [IDX_W-1:0] idx;
	} tlic_win_t;

	typedef struct packed {
		logic instr_done;
		logic ack;
		logic reti;
	} tlic_cpu_t;

	////////////////////////////////////////////////////////////////////////////////
	// per-source bit gathered from the base and extended registers
	function automatic logic [NUM_SRC-1:0] tlic_src_bits(input logic [DW-1:0] base,
			input logic [DW-1:0] ext);
		tlic_src_bits = {ext[EIE_SRC_W-1:0], base[IE_SRC_W-1:0]};
	endfunction

	function automatic logic [VW-1:0] tlic_vec_of(input logic [IDX_W-1:0] idx);
		logic [VW-1:0] wide;
		wide = {{(VW-IDX_W){1'b0}}, idx};
		tlic_vec_of = VEC_BASE + ((wide << 3) & ~VEC_STEP + VEC_STEP) * 16'h0000 + (wide << 3);
	endfunction

endpackage

// File: tlic_arb.sv
// two-level fixed-order arbiter of the interrupt controller
`timescale 1ns/1ps
module tlic_arb
	import tlic_pkg::*;
(
	input wire logic [NUM_SRC-1:0] req,
	input wire logic [NUM_SRC-1:0] prio,
	input wire logic busy_lo,
	input wire logic busy_hi,
	output tlic_win_t win
);

	logic [NUM_SRC-1:0] hi_req;
	logic [NUM_SRC-1:0] lo_req;
	logic hi_ok;
	logic lo_ok;

	////////////////////////////////////////////////////////////////////////////////
	// eligibility by level
	always_comb begin
		hi_ok = !busy_hi;
		lo_ok = !busy_hi && !busy_lo;
		hi_req = hi_ok ? (req & prio) : '0;
		lo_req = lo_ok ? (req & ~prio) : '0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// high level first, lowest index wins inside a level
	always_comb begin
		win = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (lo_req[i]) begin
				win.valid = 1'b1;
				win.level = 1'b0;
				win.idx = IDX_W'(i);
			end
		end
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (hi_req[i]) begin
				win.valid = 1'b1;
				win.level = 1'b1;
				win.idx = IDX_W'(i);
			end
		end
	end

endmodule

// File: tlic_core.sv
// two-level interrupt controller: pending flags, enables, arbitration, cpu request
//
// Summary of operation
// - twelve sources, each low or high level
// - valid condition sets pending flag regardless of enables
// - enabled pending flag requests a vectored long call
// - disabled source pending flag makes no request
// - global enable bit 7 masks every source
// - masked flags stay pending until global enable
// - one-cycle follower may still take stale request
// - vectoring never clears pending flags in hardware
// - flag set after return re-enters after one instruction
// - software writing one to flag raises request
// - high preempts low, high never preempted
// - higher level first, then fixed source order
// - sampled every clock, five-cycle least response
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module tlic_core
	import tlic_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [AW-1:0] reg_addr,
	input wire logic [DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DW-1:0] reg_rdata,
	input wire logic [NUM_SRC-1:0] src_set,
	input wire tlic_cpu_t cpu_in,
	output logic cpu_irq,
	output logic [VW-1:0] cpu_vec,
	output logic cpu_level,
	output logic irq_evt
);

	////////////////////////////////////////////////////////////////////////////////
	// state
	logic [DW-1:0] ie_q, ie_d;
	logic [DW-1:0] ip_q, ip_d;
	logic [DW-1:0] eie_q, eie_d;
	logic [DW-1:0] eip_q, eip_d;
	logic [NUM_SRC-1:0] pend_q, pend_d;
	logic [NUM_SRC-1:0] req_q, req_d;
	logic [EVT_W-1:0] stat_q, stat_d;
	logic [EVT_W-1:0] evt_en_q, evt_en_d;
	logic [DW-1:0] rdata_q, rdata_d;
	logic in_lo_q, in_lo_d;
	logic in_hi_q, in_hi_d;
	logic hold_q, hold_d;
	tlic_win_t win_q, win_d;
	logic [VW-1:0] vec_q, vec_d;

	logic [NUM_SRC-1:0] en_vec;
	logic [NUM_SRC-1:0] prio_vec;
	logic ea;
	logic [EVT_W-1:0] evt;
	logic wr_pend_lo;
	logic wr_pend_hi;

	////////////////////////////////////////////////////////////////////////////////
	// register writes
	always_comb begin
		wr_pend_lo = reg_wr && (reg_addr == ADDR_PEND_LO);
		wr_pend_hi = reg_wr && (reg_addr == ADDR_PEND_HI);
		ie_d = ie_q;
		ip_d = ip_q;
		eie_d = eie_q;
		eip_d = eip_q;
		evt_en_d = evt_en_q;
		pend_d = pend_q;
		if (reg_wr) begin
			case (reg_addr)
				ADDR_IE: ie_d = reg_wdata;
				ADDR_IP: ip_d = reg_wdata;
				ADDR_EIE: eie_d = reg_wdata;
				ADDR_EIP: eip_d = reg_wdata;
				ADDR_EVT_EN: evt_en_d = reg_wdata[EVT_W-1:0];
				ADDR_PEND_LO: pend_d[DW-1:0] = reg_wdata;
				ADDR_PEND_HI: pend_d[NUM_SRC-1:DW] = reg_wdata[PEND_HI_W-1:0];
				default: ;
			endcase
		end
		// a hardware set wins over a software clear in the same cycle
		pend_d = pend_d | src_set;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ie_q <= REG_RST;
			ip_q <= REG_RST;
			eie_q <= REG_RST;
			eip_q <= REG_RST;
			evt_en_q <= '0;
			pend_q <= '0;
		end else begin
			ie_q <= ie_d;
			ip_q <= ip_d;
			eie_q <= eie_d;
			eip_q <= eip_d;
			evt_en_q <= evt_en_d;
			pend_q <= pend_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// request formation, sampled every clock
	always_comb begin
		en_vec = tlic_src_bits(ie_q, eie_q);
		prio_vec = tlic_src_bits(ip_q, eip_q);
		ea = ie_q[EA_BIT];
		// a disabled source or a clear global enable gives no request
		req_d = pend_q & en_vec & {NUM_SRC{ea}};
	end

	////////////////////////////////////////////////////////////////////////////////
	// active level tracking and post-return hold
	always_comb begin
		in_lo_d = in_lo_q;
		in_hi_d = in_hi_q;
		hold_d = hold_q;
		if (cpu_in.reti) begin
			if (in_hi_q) begin
				in_hi_d = 1'b0;
			end else begin
				in_lo_d = 1'b0;
			end
			hold_d = 1'b1;
		end else if (cpu_in.instr_done) begin
			hold_d = 1'b0;
		end
		if (cpu_in.ack && cpu_irq) begin
			if (win_q.level) begin
				in_hi_d = 1'b1;
			end else begin
				in_lo_d = 1'b1;
			end
		end
	end

	tlic_arb u_arb (
		.req(req_d),
		.prio(prio_vec),
		.busy_lo(in_lo_d),
		.busy_hi(in_hi_d),
		.win(win_d)
	);

	always_comb begin
		vec_d = win_d.valid ? tlic_vec_of(win_d.idx) : vec_q;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_q <= '0;
			in_lo_q <= 1'b0;
			in_hi_q <= 1'b0;
			hold_q <= 1'b0;
			win_q <= '0;
			vec_q <= '0;
		end else begin
			req_q <= req_d;
			in_lo_q <= in_lo_d;
			in_hi_q <= in_hi_d;
			hold_q <= hold_d;
			win_q <= win_d;
			vec_q <= vec_d;
		end
	end

	// a request registered just before an enable clear lasts one more cycle
	always_comb begin
		cpu_irq = win_q.valid && !(hold_q && !cpu_in.instr_done);
		cpu_vec = vec_q;
		cpu_level = win_q.level;
	end

	////////////////////////////////////////////////////////////////////////////////
	// event status, clear and enable
	always_comb begin
		evt = '0;
		evt[EVT_TAKE_LO] = cpu_in.ack && cpu_irq && !win_q.level;
		evt[EVT_TAKE_HI] = cpu_in.ack && cpu_irq && win_q.level;
		evt[EVT_RETI] = cpu_in.reti;
		stat_d = stat_q;
		if (reg_wr && (reg_addr == ADDR_EVT_CLR)) begin
			stat_d = stat_q & ~reg_wdata[EVT_W-1:0];
		end
		stat_d = stat_d | evt;
	end

	////////////////////////////////////////////////////////////////////////////////
	// register reads, data in the following cycle
	always_comb begin
		rdata_d = '0;
		if (reg_rd) begin
			case (reg_addr)
				ADDR_IE: rdata_d = ie_q;
				ADDR_IP: rdata_d = ip_q;
				ADDR_EIE: rdata_d = eie_q;
				ADDR_EIP: rdata_d = eip_q;
				ADDR_PEND_LO: rdata_d = pend_q[DW-1:0];
				ADDR_PEND_HI: rdata_d = {{(DW-PEND_HI_W){1'b0}}, pend_q[NUM_SRC-1:DW]};
				ADDR_EVT_STAT: rdata_d = {{(DW-EVT_W){1'b0}}, stat_q};
				ADDR_EVT_EN: rdata_d = {{(DW-EVT_W){1'b0}}, evt_en_q};
				ADDR_ACTIVE: rdata_d = {{(DW-2){1'b0}}, in_hi_q, in_lo_q};
				default: rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_q <= '0;
			rdata_q <= '0;
		end else begin
			stat_q <= stat_d;
			rdata_q <= rdata_d;
		end
	end

	always_comb begin
		reg_rdata = rdata_q;
		irq_evt = |(stat_q & evt_en_q);
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	sequence reti_seq;
		cpu_in.reti && !cpu_in.ack;
	endsequence

	sequence idle_rise_seq;
		!in_lo_q && !in_hi_q && !hold_q && !cpu_in.reti && !cpu_in.ack && $rose(|req_q);
	endsequence

	flag_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		|src_set |=> ((pend_q & $past(src_set)) == $past(src_set)))
		else $error("pending flag not set by source");

	req_form_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		##1 req_q == ($past(pend_q) & $past(en_vec) & {NUM_SRC{$past(ea)}}))
		else $error("request not flag and enable and global");

	global_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!ea ##1 !ea |=> !win_q.valid)
		else $error("request while global enable clear");

	disabled_src_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		##1 (req_q & ~$past(en_vec)) == '0)
		else $error("disabled source made a request");

	masked_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!ea && !wr_pend_lo && !wr_pend_hi |=> ((pend_q & $past(pend_q)) == $past(pend_q)))
		else $error("masked pending flag lost");

	ack_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cpu_in.ack && !wr_pend_lo && !wr_pend_hi
		|=> ((pend_q & $past(pend_q)) == $past(pend_q)))
		else $error("vectoring cleared a pending flag");

	sw_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wr_pend_lo && reg_wdata[0] && en_vec[0] && ea ##1 ea && en_vec[0] && !hold_q
		&& !in_lo_q && !in_hi_q && !cpu_in.ack |=> cpu_irq && win_q.idx == '0)
		else $error("software set flag gave no request");

	reti_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reti_seq |=> (!cpu_irq || cpu_in.instr_done) until_with cpu_in.instr_done)
		else $error("request before one instruction after return");

	reti_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reti_seq ##1 cpu_in.instr_done && win_q.valid |-> cpu_irq)
		else $error("no re-entry after instruction following return");

	hi_no_preempt_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		in_hi_q |-> !cpu_irq)
		else $error("high level routine preempted");

	lo_preempt_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cpu_irq && in_lo_q |-> win_q.level)
		else $error("low request during low routine");

	level_order_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cpu_irq && !win_q.level && !in_lo_q |-> (req_q & $past(prio_vec)) == '0)
		else $error("low served before high");

	fixed_order_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cpu_irq && !win_q.level && !in_lo_q
		|-> (req_q & ((NUM_SRC'(1) << win_q.idx) - NUM_SRC'(1))) == '0)
		else $error("fixed source order broken");

	response_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		idle_rise_seq |-> ##[0:1] cpu_irq)
		else $error("request not presented within detect cycle");

	vector_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cpu_irq |-> cpu_vec == VEC_BASE + {{(VW-IDX_W-3){1'b0}}, win_q.idx, 3'b000})
		else $error("wrong vector address");

	evt_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cpu_in.ack && cpu_irq |=> stat_q[EVT_TAKE_LO] || stat_q[EVT_TAKE_HI])
		else $error("taken event not recorded");

endmodule

// File: tlic_cpu_model.sv
// behavioural cpu that takes and returns from the controller's requests
`timescale 1ns/1ps
module tlic_cpu_model
	import tlic_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic reti_go,
	input wire logic cpu_irq,
	output tlic_cpu_t cpu_in
);
	logic [1:0] cnt_q;
	logic ack_q;
	logic reti_q;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 2'h0;
			ack_q <= 1'b0;
			reti_q <= 1'b0;
		end else begin
			cnt_q <= (cnt_q == 2'h0) ? {slow, 1'b0} : cnt_q - 2'h1;
			ack_q <= cpu_in.instr_done & cpu_irq & ~ack_q;
			reti_q <= reti_go;
		end
	end
	// no instruction boundary during the return or the call start
	assign cpu_in.instr_done = (cnt_q == 2'h0) & ~reti_q & ~ack_q;
	assign cpu_in.ack = ack_q;
	assign cpu_in.reti = reti_q;
endmodule

// File: two_level_interrupt_controller_tb.sv
// self-checking bench of the two-level interrupt controller with a cpu model
`timescale 1ns/1ps
module two_level_interrupt_controller_tb
	import tlic_pkg::*;
();
	localparam logic [AW-1:0] RST_ADDR [9] = '{ADDR_IE, ADDR_IP, ADDR_EIE, ADDR_EIP,
		ADDR_PEND_LO, ADDR_PEND_HI, ADDR_EVT_STAT, ADDR_ACTIVE, 8'h7F};
	logic sys_clk;
	logic rst_n = 1'b0;
	logic [AW-1:0] reg_addr = '0;
	logic [DW-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [NUM_SRC-1:0] src_set = '0;
	logic slow = 1'b0;
	logic reti_go = 1'b0;
	logic rd_seen = 1'b0;
	logic [DW-1:0] reg_rdata;
	logic cpu_irq;
	logic cpu_level;
	logic irq_evt;
	logic [VW-1:0] cpu_vec;
	tlic_cpu_t cpu_in;
	logic [DW-1:0] rd_q[$];
	logic [VW:0] tk_q[$];
	logic [31:0] seed;
	int err_count = 0;
	int n_checks = 0;
	int n_takes = 0;

	tlic_core tlic_core_i (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.src_set(src_set),
		.cpu_in(cpu_in),
		.cpu_irq(cpu_irq),
		.cpu_vec(cpu_vec),
		.cpu_level(cpu_level),
		.irq_evt(irq_evt)
	);
	tlic_cpu_model tlic_cpu_model_i (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.slow(slow),
		.reti_go(reti_go),
		.cpu_irq(cpu_irq),
		.cpu_in(cpu_in)
	);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xorshift(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		xorshift = y ^ (y << 5);
	endfunction
	function automatic logic [VW-1:0] vec(input int i);
		vec = VEC_BASE + VEC_STEP * VW'(i);
	endfunction
	task automatic cmp_val(input string what, input logic [VW:0] e, input logic [VW:0] s);
		n_checks++;
		if (s !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic cmp_bit(input string what, input logic e, input logic s);
		n_checks++;
		if (s !== e) begin
			err_count++;
			$display("ERROR %s expected %b seen %b", what, e, s);
		end
	endtask
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
		rd_q.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic exp_take(input int i, input logic l);
		tk_q.push_back({l, vec(i)});
	endtask
	task automatic wait_takes(input int n);
		int k;
		k = 0;
		while (n_takes < n && k < 200) begin
			@(posedge sys_clk);
			k++;
		end
		cmp_bit("take count", 1'b1, n_takes >= n);
	endtask
	task automatic serve(input logic [AW-1:0] a, input logic [DW-1:0] d);
		wr(a, d);
		reti_go <= 1'b1;
		@(posedge sys_clk);
		reti_go <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask
	task automatic pulse(input int i);
		src_set <= NUM_SRC'(1) << i;
		@(posedge sys_clk);
		src_set <= '0;
		@(posedge sys_clk);
	endtask
	task automatic quiet(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			#1 cmp_bit("cpu_irq", 1'b0, cpu_irq);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// result watcher: read data and taken vectors against the oldest note
	always @(posedge sys_clk) begin
		rd_seen <= reg_rd;
		if (rd_seen === 1'b1) begin
			if (rd_q.size() == 0) cmp_bit("read note", 1'b0, 1'b1);
			else cmp_val("reg_rdata", {9'h000, rd_q.pop_front()}, {9'h000, reg_rdata});
		end
		if (cpu_in.ack === 1'b1) begin
			n_takes++;
			if (tk_q.size() == 0) cmp_bit("take note", 1'b0, 1'b1);
			else cmp_val("vector", tk_q.pop_front(), {cpu_level, cpu_vec});
		end
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		err_count++;
		tally_and_finish;
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		for (int k = 0; k < 9; k++) rd(RST_ADDR[k], REG_RST);
		seed = 32'hf122_752e;
		for (int k = 0; k < 4; k++) begin
			seed = xorshift(seed);
			wr(RST_ADDR[k], seed[7:0]);
			rd(RST_ADDR[k], seed[7:0]);
			wr(RST_ADDR[k], REG_RST);
		end
		wr(8'h7F, 8'hA5);
		rd(8'h7F, 8'h00);
		wr(ADDR_EVT_STAT, 8'hFF);
		rd(ADDR_EVT_STAT, 8'h00);
		wr(ADDR_EVT_EN, 8'h07);
		// masked pending flag, then global enable
		pulse(3);
		rd(ADDR_PEND_LO, 8'h08);
		wr(ADDR_IE, 8'h08);
		quiet(8);
		wr(ADDR_IE, 8'h81);
		quiet(8);
		exp_take(3, 1'b0);
		wr(ADDR_IE, 8'h88);
		wait_takes(1);
		rd(ADDR_PEND_LO, 8'h08);
		rd(ADDR_ACTIVE, 8'h01);
		rd(ADDR_EVT_STAT, 8'h01);
		#1 cmp_bit("irq_evt", 1'b1, irq_evt);
		wr(ADDR_EVT_CLR, 8'h01);
		#1 cmp_bit("irq_evt", 1'b0, irq_evt);
		// return with the flag still set re-enters
		exp_take(3, 1'b0);
		serve(ADDR_IE, 8'h88);
		wait_takes(2);
		serve(ADDR_PEND_LO, 8'h00);
		quiet(8);
		rd(ADDR_ACTIVE, 8'h00);
		rd(ADDR_EVT_STAT, 8'h05);
		wr(ADDR_EVT_EN, 8'h00);
		#1 cmp_bit("irq_evt", 1'b0, irq_evt);
		wr(ADDR_EVT_EN, 8'h04);
		#1 cmp_bit("irq_evt", 1'b1, irq_evt);
		wr(ADDR_EVT_CLR, 8'h07);
		rd(ADDR_EVT_STAT, 8'h00);
		// two levels, preemption and fixed order
		wr(ADDR_IP, 8'h11);
		wr(ADDR_IE, 8'h13);
		wr(ADDR_EIE, 8'h0C);
		wr(ADDR_PEND_HI, 8'h06);
		wr(ADDR_PEND_LO, 8'h02);
		exp_take(1, 1'b0);
		exp_take(4, 1'b1);
		exp_take(0, 1'b1);
		exp_take(9, 1'b0);
		exp_take(10, 1'b0);
		wr(ADDR_IE, 8'h93);
		wait_takes(3);
		wr(ADDR_PEND_LO, 8'h12);
		wait_takes(4);
		pulse(0);
		quiet(8);
		serve(ADDR_PEND_LO, 8'h03);
		wait_takes(5);
		serve(ADDR_PEND_LO, 8'h02);
		quiet(8);
		serve(ADDR_PEND_LO, 8'h00);
		wait_takes(6);
		serve(ADDR_PEND_HI, 8'h04);
		wait_takes(7);
		serve(ADDR_PEND_HI, 8'h00);
		// fastest detect with a slow cpu
		slow <= 1'b1;
		wr(ADDR_IP, 8'h00);
		wr(ADDR_IE, 8'h81);
		exp_take(0, 1'b0);
		src_set <= NUM_SRC'(1);
		@(posedge sys_clk);
		src_set <= '0;
		#1 cmp_bit("cpu_irq", 1'b0, cpu_irq);
		@(posedge sys_clk);
		#1 cmp_bit("cpu_irq", 1'b1, cpu_irq);
		wait_takes(8);
		serve(ADDR_PEND_LO, 8'h00);
		quiet(8);
		// software set of an enabled flag vectors like a hardware set
		exp_take(0, 1'b0);
		wr(ADDR_PEND_LO, 8'h01);
		wait_takes(9);
		serve(ADDR_PEND_LO, 8'h00);
		// global enable cleared twice in a row, then a masked source stays pending
		wr(ADDR_IE, 8'h01);
		wr(ADDR_IE, 8'h01);
		pulse(0);
		quiet(8);
		rd(ADDR_PEND_LO, 8'h01);
		tally_and_finish;
	end
endmodule
